// [urh_pkg.sv]
// Purpose: Shared constants, register map and types of the handshaked serial channel.
// Assumes: 32-bit Avalon-MM register window, one register per aligned word.
// Notes: The MODE, BRG, OSC and CTRL reset values and the field positions live here, except the BRG n/k nibbles and MODE bit 6, which urh_uart hardcodes.
package urh_pkg;

	localparam logic [4:0] OFS_TX   = 5'h00;
	localparam logic [4:0] OFS_RX   = 5'h04;
	localparam logic [4:0] OFS_MODE = 5'h08;
	localparam logic [4:0] OFS_STAT = 5'h0C;
	localparam logic [4:0] OFS_BRG  = 5'h10;
	localparam logic [4:0] OFS_OSC  = 5'h14;
	localparam logic [4:0] OFS_EVT  = 5'h18;
	localparam logic [4:0] OFS_CTRL = 5'h1C;

	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] BRG_RST  = 8'h8B;
	localparam logic [7:0] OSC_RST  = 8'h01;
	localparam logic [7:0] CTRL_RST = 8'h00;

	localparam int EVT_TX_END  = 0;
	localparam int EVT_TX_BUSY = 1;
	localparam int EVT_RX_DONE = 2;
	localparam int OSC_HALVE   = 0;
	localparam int CTRL_EXT    = 0;

	localparam logic [3:0] N_MIN = 4'h1;
	localparam logic [3:0] N_MAX = 4'hB;
	localparam logic [3:0] K_MAX = 4'hE;
	localparam logic [4:0] K_ADD = 5'h10;
	localparam logic [3:0] N_BIAS = 4'h4;

	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD  = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;

	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] LAST_BIT7 = 4'h6;

	typedef struct packed {
		logic       tx_en;
		logic       receive_enable_bit;
		logic [1:0] parity;
		logic       char8;
		logic       stop2;
		logic       rx_error_irq_suppress;
		logic       rsv;
	} urh_mode_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} urh_av_req_t;

	typedef struct packed {
		logic parity;
		logic framing;
		logic overrun;
	} urh_err_t;

	typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} urh_tx_state_t;
	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} urh_rx_state_t;

endpackage

// [urh_baud_gen.sv]
// Purpose: Half-bit tick generator; two ticks make one bit of fxx/(2^n*(k+16)).
// Assumes: i_src_tick marks one cycle of the selected source clock.
// Notes: Out-of-range n and k are clamped so the divider never reaches zero.
`timescale 1ns/1ns
module urh_baud_gen #(
	parameter int CW = 15
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_src_tick,
	input  wire logic       i_restart,
	input  wire logic [3:0] i_n,
	input  wire logic [3:0] i_k,
	output logic            o_half_tick
);
	import urh_pkg::*;

	logic [3:0]    n_eff;
	logic [3:0]    k_eff;
	logic [CW-1:0] half_len;
	logic [CW-1:0] cnt_ff;

	always_comb begin
		// Code 0 is the slowest prescale and codes 5 to 15 give n = code - 4.
		// Codes 1 to 4 are unused and fall back to n = 1.
		if (i_n == 4'h0)
			n_eff = N_MAX;
		else if (i_n <= N_BIAS)
			n_eff = N_MIN;
		else
			n_eff = i_n - N_BIAS;
		k_eff = (i_k > K_MAX) ? K_MAX : i_k;
		// Widen before shifting, or the upper prescale steps would be lost.
		// Half a bit is 2^(n-1)*(k+16) source cycles, so a whole bit is 2^n*(k+16).
		half_len = CW'({1'b0, k_eff} + K_ADD) << (n_eff - 4'h1);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || i_restart) begin
			cnt_ff      <= '0;
			o_half_tick <= 1'b0;
		end else begin
			o_half_tick <= 1'b0;
			if (i_src_tick) begin
				if (cnt_ff == half_len - CW'(1)) begin
					cnt_ff      <= '0;
					o_half_tick <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + CW'(1);
				end
			end
		end
	end

endmodule

// [urh_uart.sv]
// Purpose: Full-duplex asynchronous serial channel with active-low request/clear-to-send handshake.
// Assumes: Avalon-MM slave with one wait state; pins are asynchronous and are synchronised here.
// Notes: Register offsets and fields are in urh_pkg.
`timescale 1ns/1ns
module urh_uart #(
	parameter int CW = 15
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire urh_pkg::urh_av_req_t i_av,
	output logic                      o_waitrequest,
	output logic [31:0]               o_readdata,
	input  wire logic                 i_rxd,
	input  wire logic                 i_cts_n,
	input  wire logic                 i_ext_baud_clk,
	output logic                      o_txd,
	output logic                      o_rts_n,
	output logic                      o_rx_end_irq,
	output logic                      o_rx_error_irq,
	output logic                      o_tx_end_irq
);
	import urh_pkg::*;

	urh_mode_t     async_mode_reg;
	logic [7:0]    baud_divider_control;
	logic [7:0]    osc_select_reg;
	logic [7:0]    ctrl_ff;
	urh_err_t      async_error_status_reg;
	logic [7:0]    rx_buffer_reg;
	logic [2:0]    sync1_ff;
	logic [2:0]    sync2_ff;
	logic          ext_prev_ff;
	logic          rxd_prev_ff;
	logic          halve_ph_ff;
	logic          src_tick;
	logic          rxd_s;
	logic          cts_s;
	logic          acc;
	logic          wr;
	logic          rd;
	logic          tx_wr;
	logic          rxb_rd;
	logic [31:0]   nxt_readdata;
	logic          tx_end_flag;
	logic          tx_busy_ff;
	logic          rx_done_indication;
	urh_tx_state_t tx_state_ff;
	logic [7:0]    tx_shift_reg;
	logic [3:0]    tx_cnt_ff;
	logic          tx_ph_ff;
	logic          tx_par_ff;
	logic          tx_ok;
	logic          tx_go;
	logic          tx_htick;
	logic [7:0]    wr_char;
	urh_rx_state_t rx_state_ff;
	logic [7:0]    rx_sh_ff;
	logic [3:0]    rx_cnt_ff;
	logic          rx_ph_ff;
	logic          rx_par_ff;
	logic          rx_restart;
	logic          rx_htick;
	logic          rx_cmpl;
	logic          rx_end_ev;
	logic [7:0]    rx_char;
	logic          par_exp;
	urh_err_t      nxt_err;
	logic [3:0]    last_bit;

	// Pins cross into the clock domain through two flip-flops each: rxd, cts_n, baud clock.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1_ff <= 3'h7;
			sync2_ff <= 3'h7;
		end else begin
			sync1_ff <= {i_ext_baud_clk, i_cts_n, i_rxd};
			sync2_ff <= sync1_ff;
		end
	end

	assign rxd_s = sync2_ff[0];
	assign cts_s = sync2_ff[1];

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ext_prev_ff <= 1'b1;
			rxd_prev_ff <= 1'b1;
			halve_ph_ff <= 1'b0;
		end else begin
			ext_prev_ff <= sync2_ff[2];
			rxd_prev_ff <= rxd_s;
			halve_ph_ff <= ~halve_ph_ff;
		end
	end

	// The external pin is edge-counted, so it must run below half the system clock.
	always_comb begin
		if (ctrl_ff[CTRL_EXT])
			src_tick = sync2_ff[2] && !ext_prev_ff;
		else if (osc_select_reg[OSC_HALVE])
			src_tick = 1'b1;
		else
			src_tick = halve_ph_ff;
	end

	assign last_bit = async_mode_reg.char8 ? LAST_BIT8 : LAST_BIT7;

	// Register bus: every access takes exactly one wait state.
	assign acc    = (i_av.read || i_av.write) && !o_waitrequest;
	assign wr     = acc && i_av.write && i_av.byteenable[0];
	assign rd     = acc && i_av.read;
	assign tx_wr  = wr && (i_av.address == OFS_TX);
	assign rxb_rd = rd && (i_av.address == OFS_RX);

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_waitrequest <= 1'b1;
		else if (o_waitrequest && (i_av.read || i_av.write))
			o_waitrequest <= 1'b0;
		else
			o_waitrequest <= 1'b1;
	end

	always_comb begin
		unique case (i_av.address)
			OFS_RX:   nxt_readdata = {24'h000000, rx_buffer_reg};
			OFS_MODE: nxt_readdata = {24'h000000, async_mode_reg};
			OFS_STAT: nxt_readdata = {29'h00000000, async_error_status_reg};
			OFS_BRG:  nxt_readdata = {24'h000000, baud_divider_control};
			OFS_OSC:  nxt_readdata = {24'h000000, osc_select_reg};
			OFS_EVT:  nxt_readdata = {29'h00000000, rx_done_indication, tx_busy_ff, tx_end_flag};
			OFS_CTRL: nxt_readdata = {24'h000000, ctrl_ff};
			default:  nxt_readdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_readdata <= 32'h00000000;
		else if (o_waitrequest && i_av.read)
			o_readdata <= nxt_readdata;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			async_mode_reg       <= MODE_RST;
			baud_divider_control <= BRG_RST;
			osc_select_reg       <= OSC_RST;
			ctrl_ff              <= CTRL_RST;
		end else if (wr) begin
			if (i_av.address == OFS_MODE)
				async_mode_reg <= i_av.writedata[7:0];
			if (i_av.address == OFS_BRG)
				baud_divider_control <= i_av.writedata[7:0];
			if (i_av.address == OFS_OSC)
				osc_select_reg <= {7'h00, i_av.writedata[OSC_HALVE]};
			if (i_av.address == OFS_CTRL)
				ctrl_ff <= {7'h00, i_av.writedata[CTRL_EXT]};
		end
	end

	// Transmitter.
	assign wr_char = async_mode_reg.char8 ? i_av.writedata[7:0] : {1'b0, i_av.writedata[6:0]};
	assign tx_ok   = tx_end_flag && !cts_s && async_mode_reg.tx_en && (tx_state_ff == T_IDLE);
	assign tx_go   = tx_wr && tx_ok;

	urh_baud_gen #(.CW(CW)) u_tx_baud (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_src_tick  (src_tick),
		.i_restart   (tx_go),
		.i_n         (baud_divider_control[7:4]),
		.i_k         (baud_divider_control[3:0]),
		.o_half_tick (tx_htick)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_state_ff  <= T_IDLE;
			tx_shift_reg <= 8'h00;
			tx_cnt_ff    <= 4'h0;
			tx_ph_ff     <= 1'b0;
			tx_par_ff    <= 1'b0;
			o_txd        <= 1'b1;
		end else if (tx_go) begin
			tx_state_ff  <= T_START;
			tx_shift_reg <= wr_char;
			tx_par_ff    <= (async_mode_reg.parity == PAR_ODD) ? ~^wr_char :
				(async_mode_reg.parity == PAR_EVEN) ? ^wr_char : 1'b0;
			tx_ph_ff     <= 1'b0;
			o_txd        <= 1'b0;
		end else if (tx_htick && tx_state_ff != T_IDLE) begin
			tx_ph_ff <= ~tx_ph_ff;
			if (tx_ph_ff) begin
				unique case (tx_state_ff)
					T_START, T_DATA: begin
						if (tx_state_ff == T_DATA && tx_cnt_ff == last_bit) begin
							tx_cnt_ff   <= 4'h0;
							tx_state_ff <= (async_mode_reg.parity == PAR_NONE) ? T_STOP : T_PAR;
							o_txd       <= (async_mode_reg.parity == PAR_NONE) ? 1'b1 : tx_par_ff;
						end else begin
							tx_cnt_ff    <= (tx_state_ff == T_START) ? 4'h0 : tx_cnt_ff + 4'h1;
							tx_state_ff  <= T_DATA;
							o_txd        <= tx_shift_reg[0];
							tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						end
					end
					T_PAR: begin
						tx_state_ff <= T_STOP;
						tx_cnt_ff   <= 4'h0;
						o_txd       <= 1'b1;
					end
					T_STOP: begin
						if (tx_cnt_ff == {3'h0, async_mode_reg.stop2})
							tx_state_ff <= T_IDLE;
						else
							tx_cnt_ff <= tx_cnt_ff + 4'h1;
					end
					T_IDLE: tx_state_ff <= T_IDLE;
				endcase
			end
		end
	end

	// The end flag leaves reset set, so the very first write may send.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_end_flag  <= 1'b1;
			o_tx_end_irq <= 1'b0;
		end else begin
			o_tx_end_irq <= 1'b0;
			if (tx_go)
				tx_end_flag <= 1'b0;
			else if (tx_htick && tx_ph_ff && tx_state_ff == T_STOP
				&& tx_cnt_ff == {3'h0, async_mode_reg.stop2}) begin
				tx_end_flag  <= 1'b1;
				o_tx_end_irq <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			tx_busy_ff <= 1'b0;
		else if (tx_wr && !tx_ok)
			tx_busy_ff <= 1'b1;
		else if (wr && i_av.address == OFS_EVT && i_av.writedata[EVT_TX_BUSY])
			tx_busy_ff <= 1'b0;
	end

	// Receiver.
	assign rx_restart = (rx_state_ff == R_IDLE) && async_mode_reg.receive_enable_bit && rxd_prev_ff && !rxd_s;

	urh_baud_gen #(.CW(CW)) u_rx_baud (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_src_tick  (src_tick),
		.i_restart   (rx_restart),
		.i_n         (baud_divider_control[7:4]),
		.i_k         (baud_divider_control[3:0]),
		.o_half_tick (rx_htick)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_state_ff <= R_IDLE;
			rx_sh_ff    <= 8'h00;
			rx_cnt_ff   <= 4'h0;
			rx_ph_ff    <= 1'b0;
			rx_par_ff   <= 1'b0;
		end else if (!async_mode_reg.receive_enable_bit) begin
			rx_state_ff <= R_IDLE;
		end else if (rx_restart) begin
			rx_state_ff <= R_START;
			rx_ph_ff    <= 1'b0;
		end else if (rx_htick) begin
			unique case (rx_state_ff)
				R_START: begin
					// Mid start bit: a high line here was only a glitch.
					rx_state_ff <= rxd_s ? R_IDLE : R_DATA;
					rx_cnt_ff   <= 4'h0;
					rx_ph_ff    <= 1'b0;
				end
				R_DATA, R_PAR, R_STOP: begin
					rx_ph_ff <= ~rx_ph_ff;
					if (rx_ph_ff) begin
						if (rx_state_ff == R_DATA) begin
							rx_sh_ff  <= {rxd_s, rx_sh_ff[7:1]};
							rx_cnt_ff <= rx_cnt_ff + 4'h1;
							if (rx_cnt_ff == last_bit)
								rx_state_ff <= (async_mode_reg.parity == PAR_NONE) ? R_STOP : R_PAR;
						end else if (rx_state_ff == R_PAR) begin
							rx_par_ff   <= rxd_s;
							rx_state_ff <= R_STOP;
						end else begin
							rx_state_ff <= R_IDLE;
						end
					end
				end
				R_IDLE: rx_state_ff <= R_IDLE;
			endcase
		end
	end

	// Only the first stop bit is checked; a second one is idle line to the receiver.
	assign rx_cmpl = async_mode_reg.receive_enable_bit && rx_htick && rx_ph_ff && (rx_state_ff == R_STOP);
	assign rx_char = async_mode_reg.char8 ? rx_sh_ff : {1'b0, rx_sh_ff[7:1]};

	always_comb begin
		par_exp         = (async_mode_reg.parity == PAR_ODD) ? ~^rx_char :
			(async_mode_reg.parity == PAR_EVEN) ? ^rx_char : 1'b0;
		nxt_err.parity  = (async_mode_reg.parity != PAR_NONE) && (rx_par_ff != par_exp);
		nxt_err.framing = !rxd_s;
		nxt_err.overrun = rx_done_indication && !rxb_rd;
		rx_end_ev       = rx_cmpl && !(async_mode_reg.rx_error_irq_suppress && (nxt_err != 3'h0));
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			rx_buffer_reg <= 8'h00;
		else if (rx_cmpl)
			rx_buffer_reg <= rx_char;
	end

	// A new character overrides a buffer read in the same cycle.
	always_ff @(posedge i_clk) begin
		if (i_rst)
			async_error_status_reg <= 3'h0;
		else if (rx_cmpl)
			async_error_status_reg <= nxt_err;
		else if (rxb_rd)
			async_error_status_reg <= 3'h0;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			rx_done_indication <= 1'b0;
		else if (rx_cmpl)
			rx_done_indication <= 1'b1;
		else if (rxb_rd || (wr && i_av.address == OFS_EVT && i_av.writedata[EVT_RX_DONE]))
			rx_done_indication <= 1'b0;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rx_end_irq   <= 1'b0;
			o_rx_error_irq <= 1'b0;
		end else begin
			o_rx_end_irq   <= rx_end_ev;
			o_rx_error_irq <= rx_cmpl && (nxt_err != 3'h0);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_rts_n <= 1'b0;
		else if (rx_end_ev)
			o_rts_n <= 1'b1;
		else if (rxb_rd || (wr && i_av.address == OFS_MODE && i_av.writedata[6]))
			o_rts_n <= 1'b0;
	end

	a_tx_refused: assert property (@(posedge i_clk) disable iff (i_rst)
		tx_wr && !tx_ok |=> tx_busy_ff && (tx_state_ff != T_START || $past(tx_state_ff) == T_START))
		else $error("refused transmit write did not set busy");
	a_tx_start_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		tx_go |=> !o_txd && !tx_end_flag && tx_state_ff == T_START)
		else $error("accepted write did not drive a start bit");
	a_tx_end_mark: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(tx_end_flag) |-> o_tx_end_irq && o_txd && tx_state_ff == T_IDLE)
		else $error("transmit end flag without idle line and request");
	a_rts_on_end: assert property (@(posedge i_clk) disable iff (i_rst)
		o_rx_end_irq |-> o_rts_n)
		else $error("receive end request without request-to-send high");
	a_rx_gated: assert property (@(posedge i_clk) disable iff (i_rst)
		!async_mode_reg.receive_enable_bit |=> rx_state_ff == R_IDLE && !o_rx_end_irq)
		else $error("receiver active while disabled");
	a_rx_buffer_move: assert property (@(posedge i_clk) disable iff (i_rst)
		rx_cmpl |=> rx_done_indication && rx_buffer_reg == $past(rx_char))
		else $error("completed character not in receive buffer");
	a_err_request: assert property (@(posedge i_clk) disable iff (i_rst)
		o_rx_error_irq |-> async_error_status_reg != 3'h0)
		else $error("receive error request with clear status");
	a_read_clears: assert property (@(posedge i_clk) disable iff (i_rst)
		rxb_rd && !rx_cmpl |=> async_error_status_reg == 3'h0)
		else $error("buffer read left error flags set");
	a_overrun_set: assert property (@(posedge i_clk) disable iff (i_rst)
		rx_cmpl && rx_done_indication && !rxb_rd |=> async_error_status_reg.overrun)
		else $error("unread buffer did not give overrun");
	a_err_suppress: assert property (@(posedge i_clk) disable iff (i_rst)
		o_rx_error_irq && $past(async_mode_reg.rx_error_irq_suppress) |-> !o_rx_end_irq)
		else $error("suppressed errored character raised receive end");

endmodule

// [urh_term_model.sv]
// Purpose: Remote terminal model facing the serial pins of the channel.
// Assumes: The bench sets bit_clks to the bit time in clk cycles before each frame.
// Notes: Frames carry 8 data bits; the receive line idles high as if pulled up.
`timescale 1ns/1ns
module urh_term_model (
	input  wire logic i_clk,
	input  wire logic i_txd,
	output logic      o_rxd,
	output logic      o_cts_n
);
	int         bit_clks = 32;
	int         tx_frames = 0;
	int         low_w = 0;
	logic [7:0] tx_byte = 8'h00;
	logic       stop_ok = 1'b0;
	time        t_fall = 0;

	initial begin
		o_rxd = 1'b1;
		o_cts_n = 1'b0;
	end

	always @(negedge i_txd) t_fall = $time;
	always @(posedge i_txd) low_w = int'(($time - t_fall) / 10);

	// Sampling in mid bit keeps the decoder clear of the edges that the channel launches.
	initial forever begin
		@(negedge i_txd);
		repeat (bit_clks / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clks) @(posedge i_clk);
			tx_byte[i] = i_txd;
		end
		repeat (bit_clks) @(posedge i_clk);
		stop_ok = i_txd;
		repeat (bit_clks) @(posedge i_clk);
		stop_ok = stop_ok & i_txd;
		tx_frames++;
	end

	task automatic send(input logic [7:0] d, input logic par_on, input logic pb, input logic sb);
		logic [11:0] f;
		int          n;
		f = par_on ? {1'b1, sb, pb, d, 1'b0} : {1'b1, 1'b1, sb, d, 1'b0};
		n = par_on ? 12 : 11;
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			o_rxd <= f[i];
			repeat (bit_clks - 1) @(posedge i_clk);
		end
	endtask

	task automatic set_cts(input logic v);
		@(posedge i_clk);
		o_cts_n <= v;
	endtask
endmodule

// [tb.sv]
// Purpose: Self-checking bench for the handshaked serial channel.
// Assumes: Baud value 0x10 with the full clock gives 32 clk cycles per bit.
// Notes: One register access at a time; the external baud clock has a 4-cycle period.
`timescale 1ns/1ns
module tb;
	import urh_pkg::*;
	logic        i_clk;
	logic        i_rst = 1'b1;
	urh_av_req_t av;
	logic        o_waitrequest;
	logic [31:0] o_readdata;
	logic        rxd, cts_n, txd, rts_n, rx_end, rx_err, tx_end;
	logic        ext_clk = 1'b0;
	logic        par_en = 1'b0;
	logic        pb;
	logic [1:0]  pm;
	int          errors = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          n_end = 0;
	int          n_err = 0;
	int          n_txe = 0;

	urh_uart u_urh_uart (.i_clk(i_clk), .i_rst(i_rst), .i_av(av), .o_waitrequest(o_waitrequest),
		.o_readdata(o_readdata), .i_rxd(rxd), .i_cts_n(cts_n), .i_ext_baud_clk(ext_clk), .o_txd(txd),
		.o_rts_n(rts_n), .o_rx_end_irq(rx_end), .o_rx_error_irq(rx_err), .o_tx_end_irq(tx_end));
	urh_term_model u_urh_term_model (.i_clk(i_clk), .i_txd(txd), .o_rxd(rxd), .o_cts_n(cts_n));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		ext_clk <= (cyc % 4) >= 2;
		cyc++;
		if (rx_end === 1'b1) n_end++;
		if (rx_err === 1'b1) n_err++;
		if (tx_end === 1'b1) n_txe++;
		if (cyc > 40000) begin
			errors++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// The request stays put until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd, output logic [31:0] rd);
		int t;
		t = 0;
		@(posedge i_clk);
		av.read <= ~wr;
		av.write <= wr;
		av.address <= a;
		av.writedata <= {24'h000000, wd};
		do begin
			@(posedge i_clk);
			t++;
		end while (o_waitrequest !== 1'b0);
		rd = o_readdata;
		av.read <= 1'b0;
		av.write <= 1'b0;
		// The slave promises exactly one wait state, so the answer is seen at the second edge.
		chk("wait_states", 32'(t), 32'h2);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		logic [31:0] x;
		bus(1'b1, a, v, x);
	endtask

	task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
		logic [31:0] x;
		bus(1'b0, a, 8'h00, x);
		chk(nm, x, {24'h000000, e});
	endtask

	// A second character written mid-frame must be dropped and flagged busy.
	task automatic tx_chk(input logic [7:0] brg, input logic [7:0] osc, input logic [7:0] ctl, input int bits);
		int f0;
		int t;
		wr(OFS_BRG, brg);
		wr(OFS_OSC, osc);
		wr(OFS_CTRL, ctl);
		u_urh_term_model.bit_clks = bits;
		f0 = u_urh_term_model.tx_frames;
		t = n_txe;
		wr(OFS_TX, 8'hA5);
		wr(OFS_TX, 8'h5A);
		while (n_txe == t && cyc < 39000) @(posedge i_clk);
		chk("tx_byte", {24'h000000, u_urh_term_model.tx_byte}, 32'h000000A5);
		chk("bit_time", 32'(u_urh_term_model.low_w), 32'(bits));
		chk("stop_bits", {31'h0, u_urh_term_model.stop_ok}, 32'h1);
		chk("frames", 32'(u_urh_term_model.tx_frames - f0), 32'h1);
		rdc("evt", OFS_EVT, 8'h03);
		wr(OFS_EVT, 8'h02);
	endtask

	task automatic rx(input logic [7:0] v, input logic b, input logic sb, input logic [7:0] st,
		input int ee, input int er, input logic rd);
		int e0;
		int r0;
		e0 = n_end;
		r0 = n_err;
		u_urh_term_model.send(v, par_en, b, sb);
		chk("rx_end", 32'(n_end - e0), 32'(ee));
		chk("rx_err", 32'(n_err - r0), 32'(er));
		if (ee > 0) chk("rts_busy", {31'h0, rts_n}, 32'h1);
		rdc("stat", OFS_STAT, st);
		if (rd) begin
			rdc("rx_buf", OFS_RX, v);
			@(posedge i_clk);
			#1 chk("rts_ready", {31'h0, rts_n}, 32'h0);
		end
	endtask

	initial begin
		av = '0;
		av.byteenable = 4'hF;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		#1 chk("rts_idle", {30'h0, rts_n, txd}, 32'h1);
		rdc("mode", OFS_MODE, MODE_RST);
		rdc("brg", OFS_BRG, BRG_RST);
		rdc("osc", OFS_OSC, OSC_RST);
		rdc("stat", OFS_STAT, 8'h00);
		rdc("evt", OFS_EVT, 8'h01);
		rdc("tx_read", OFS_TX, 8'h00);
		$display("test reset done");
		wr(OFS_MODE, 8'hCC);
		rdc("mode", OFS_MODE, 8'hCC);
		tx_chk(8'h10, 8'h01, 8'h00, 32);
		tx_chk(8'h1E, 8'h01, 8'h00, 60);
		tx_chk(8'h10, 8'h00, 8'h00, 64);
		// Prescale code 8 with k = 11 is 16 * 27 cycles per bit, and code 7 on the halved clock matches it.
		tx_chk(8'h8B, 8'h01, 8'h00, 432);
		tx_chk(8'h7B, 8'h00, 8'h00, 432);
		tx_chk(8'h10, 8'h01, 8'h01, 128);
		wr(OFS_CTRL, 8'h00);
		$display("test transmit done");
		u_urh_term_model.set_cts(1'b1);
		repeat (4) @(posedge i_clk);
		pm = 2'(u_urh_term_model.tx_frames);
		wr(OFS_TX, 8'hA5);
		repeat (600) @(posedge i_clk);
		chk("cts_hold", {30'h0, 2'(u_urh_term_model.tx_frames)}, {30'h0, pm});
		rdc("evt_busy", OFS_EVT, 8'h03);
		wr(OFS_EVT, 8'h02);
		rdc("evt_clr", OFS_EVT, 8'h01);
		u_urh_term_model.set_cts(1'b0);
		$display("test handshake done");
		u_urh_term_model.bit_clks = 32;
		rx(8'h3C, 1'b0, 1'b1, 8'h00, 1, 0, 1'b1);
		rx(8'h96, 1'b0, 1'b0, 8'h02, 1, 1, 1'b1);
		rx(8'h11, 1'b0, 1'b1, 8'h00, 1, 0, 1'b0);
		rx(8'h22, 1'b0, 1'b1, 8'h01, 1, 1, 1'b1);
		rx(8'h55, 1'b0, 1'b0, 8'h02, 1, 1, 1'b0);
		wr(OFS_EVT, 8'h04);
		rx(8'h66, 1'b0, 1'b1, 8'h00, 1, 0, 1'b1);
		wr(OFS_MODE, 8'hCE);
		rx(8'h5A, 1'b0, 1'b0, 8'h02, 0, 1, 1'b1);
		wr(OFS_MODE, 8'h8C);
		rx(8'h5A, 1'b0, 1'b1, 8'h00, 0, 0, 1'b0);
		par_en = 1'b1;
		for (int p = 1; p < 4; p++) begin
			pm = 2'(p);
			pb = (pm == PAR_ZERO) ? 1'b0 : (pm == PAR_ODD) ? ~^8'h07 : ^8'h07;
			wr(OFS_MODE, {2'b11, pm, 4'hC});
			rx(8'h07, pb, 1'b1, 8'h00, 1, 0, 1'b1);
			rx(8'h07, ~pb, 1'b1, 8'h04, 1, 1, 1'b1);
		end
		$display("test receive done");
		end_sim();
	end
endmodule
